// File: hw/sel_loader.sv
// Serial memory loader that fills configuration registers after reset
`timescale 1ns/1ns
`default_nettype none
module sel_loader #(
	parameter int HALF_CYCLES = sel_pkg::SEL_HALF_CYC,
	parameter int GAP_CYCLES  = sel_pkg::SEL_CS_GAP_CYC
) (
	input  wire logic              i_clock,
	input  wire logic              i_reset_n,
	input  wire logic              i_link_clock,
	output logic                   o_memory_serial_clock,
	output logic                   o_serial_data_to_memory,
	input  wire logic              i_serial_data_from_memory,
	output logic                   o_memory_select_n,
	output logic                   o_csr_valid,
	input  wire logic              i_csr_ready,
	output sel_pkg::sel_rec_s      o_csr_rec,
	input  wire logic              i_cmd_valid,
	input  wire sel_pkg::sel_cmd_s i_cmd,
	output logic                   o_cmd_taken,
	output logic                   o_rd_valid,
	output logic [7:0]             o_rd_data,
	output logic                   o_busy,
	output logic                   o_loading,
	output logic                   o_load_done,
	output logic                   o_no_memory,
	output logic                   o_addr16,
	input  wire logic              i_req_valid,
	input  wire logic              i_req_cfg,
	output logic                   o_resp_valid,
	output logic                   o_resp_retry,
	output logic                   o_resp_ur
);
	import sel_pkg::*;

	logic [1:0]  lk_rst_sync;
	logic        lk_rst_n;
	logic        lk_miso_m, lk_miso_s, lk_cmd_m, lk_cmd_s, lk_ack_m, lk_ack_s, lk_cmd_seen;
	sel_state_e  state;
	sel_instr_e  instr, gap_instr;
	logic        gap_go, use16, try16, bit_run, shifting, tick, byte_done;
	logic        loading, busy, done, no_mem, mode16, rec_tog, cmd_ack;
	logic [7:0]  half_cnt;
	logic [2:0]  bit_cnt, byte_idx;
	logic [3:0]  gap_cnt;
	logic [7:0]  tx_sh, rx_sh, tx_byte, lo_byte, rd_q;
	logic [15:0] pos, remaining, cur_addr;
	sel_rec_s    rec_buf, rec_q;
	sel_cmd_s    cmd_hold;
	sel_stat_s   sy_m, sy_s;
	logic        rec_seen, cmd_tog, ack_seen, was_read, rec_pend, buf_ready, loading_all;

	// Link reset release aligned to the link clock
	always_ff @(posedge i_link_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			lk_rst_sync <= 2'h0;
		end else begin
			lk_rst_sync <= {lk_rst_sync[0], 1'b1};
		end
	end
	assign lk_rst_n = lk_rst_sync[1];

	// Return pin and system toggles into the link domain
	always_ff @(posedge i_link_clock or negedge lk_rst_n) begin
		if (!lk_rst_n) begin
			{lk_miso_m, lk_miso_s, lk_cmd_m, lk_cmd_s, lk_ack_m, lk_ack_s} <= 6'h00;
		end else begin
			{lk_miso_m, lk_cmd_m, lk_ack_m} <= {i_serial_data_from_memory, cmd_tog, rec_seen};
			{lk_miso_s, lk_cmd_s, lk_ack_s} <= {lk_miso_m, lk_cmd_m, lk_ack_m};
		end
	end

	// Bit engine timing
	assign shifting  = (state == SEL_ST_OP) || (state == SEL_ST_ADDR) || (state == SEL_ST_DATA);
	assign tick      = bit_run && (half_cnt == 8'(HALF_CYCLES - 1));
	assign byte_done = tick && o_memory_serial_clock && (bit_cnt == 3'h7);
	assign cur_addr  = (instr == SEL_I_LOAD) ? 16'h0000 : cmd_hold.addr;

	// Byte to send in the current phase
	always_comb begin
		tx_byte = 8'h00;
		case (state)
			SEL_ST_OP: begin
				case (instr)
					SEL_I_WREN:  tx_byte = SEL_OP_WREN;
					SEL_I_WRITE: tx_byte = SEL_OP_WRITE;
					SEL_I_RDSR:  tx_byte = SEL_OP_RDSR;
					default:     tx_byte = SEL_OP_READ;
				endcase
				if (!use16 && instr != SEL_I_WREN && instr != SEL_I_RDSR) begin
					tx_byte[SEL_OP_A8_BIT] = cur_addr[8];
				end
			end
			SEL_ST_ADDR: tx_byte = (use16 && byte_idx == 3'h0) ? cur_addr[15:8] : cur_addr[7:0];
			SEL_ST_DATA: tx_byte = (instr == SEL_I_WRITE) ? cmd_hold.data : 8'h00;
			default:     tx_byte = 8'h00;
		endcase
	end

	// Serial clock, output shifter and input sampler
	always_ff @(posedge i_link_clock or negedge lk_rst_n) begin
		if (!lk_rst_n) begin
			o_memory_serial_clock   <= 1'b0;
			o_serial_data_to_memory <= 1'b0;
			{half_cnt, bit_cnt, bit_run, tx_sh, rx_sh} <= '0;
		end else if (!shifting) begin
			o_memory_serial_clock <= 1'b0;
			{half_cnt, bit_cnt, bit_run} <= '0;
		end else if (!bit_run) begin
			bit_run                 <= 1'b1;
			tx_sh                   <= tx_byte;
			o_serial_data_to_memory <= tx_byte[7];
		end else if (!tick) begin
			half_cnt <= half_cnt + 8'h01;
		end else begin
			half_cnt              <= 8'h00;
			o_memory_serial_clock <= !o_memory_serial_clock;
			if (!o_memory_serial_clock) begin
				rx_sh <= {rx_sh[6:0], lk_miso_s};
			end else begin
				bit_cnt <= bit_cnt + 3'h1;
				if (bit_cnt == 3'h7) begin
					bit_run <= 1'b0;
				end else begin
					o_serial_data_to_memory <= tx_sh[6];
					tx_sh                   <= {tx_sh[6:0], 1'b0};
				end
			end
		end
	end

	// Instruction sequencer, image parser and command runner
	always_ff @(posedge i_link_clock or negedge lk_rst_n) begin
		if (!lk_rst_n) begin
			state     <= SEL_ST_GAP;
			gap_go    <= 1'b1;
			gap_instr <= SEL_I_LOAD;
			instr     <= SEL_I_LOAD;
			o_memory_select_n <= 1'b1;
			loading   <= 1'b1;
			{gap_cnt, use16, try16, mode16, no_mem, busy, done, byte_idx, pos, remaining} <= '0;
			{lo_byte, rd_q, rec_buf, rec_q, rec_tog, cmd_ack, lk_cmd_seen} <= '0;
		end else begin
			case (state)
				SEL_ST_IDLE: begin
					// Loading ends once the last record is acknowledged
					if (loading && rec_tog == lk_ack_s) begin
						loading <= 1'b0;
					end
					if (lk_cmd_s != lk_cmd_seen) begin
						lk_cmd_seen       <= lk_cmd_s;
						instr             <= cmd_hold.write ? SEL_I_WREN : SEL_I_READ;
						busy              <= cmd_hold.write;
						use16             <= mode16;
						o_memory_select_n <= 1'b0;
						state             <= SEL_ST_OP;
					end
				end
				SEL_ST_OP: if (byte_done) begin
					byte_idx <= 3'h0;
					if (instr == SEL_I_WREN) begin
						{o_memory_select_n, gap_go} <= 2'h3;
						gap_instr                   <= SEL_I_WRITE;
						state                       <= SEL_ST_GAP;
					end else begin
						state <= (instr == SEL_I_RDSR) ? SEL_ST_DATA : SEL_ST_ADDR;
					end
				end
				SEL_ST_ADDR: if (byte_done) begin
					byte_idx <= byte_idx + 3'h1;
					if (!use16 || byte_idx == 3'h1) begin
						byte_idx <= 3'h0;
						state    <= SEL_ST_DATA;
					end
				end
				SEL_ST_DATA: if (byte_done) begin
					case (instr)
						SEL_I_LOAD: begin
							pos     <= pos + 16'h0001;
							lo_byte <= rx_sh;
							if (pos == SEL_LOC_ID_HI) begin
								if ({rx_sh, lo_byte} == SEL_ID_CODE) begin
									mode16 <= try16;
								end else if (!try16) begin
									try16 <= 1'b1;
									pos   <= 16'h0000;
									{o_memory_select_n, gap_go} <= 2'h3;
									gap_instr                   <= SEL_I_LOAD;
									state                       <= SEL_ST_GAP;
								end else begin
									{no_mem, loading, done} <= 3'h5;
									{o_memory_select_n, gap_go} <= 2'h2;
									state                       <= SEL_ST_GAP;
								end
							end else if (pos == SEL_LOC_CNT_HI) begin
								remaining <= {rx_sh, lo_byte};
								if ({rx_sh, lo_byte} == 16'h0000) begin
									{loading, done} <= 2'h1;
									{o_memory_select_n, gap_go} <= 2'h2;
									state                       <= SEL_ST_GAP;
								end
							end else if (pos >= SEL_LOC_REC0) begin
								byte_idx <= byte_idx + 3'h1;
								case (byte_idx)
									3'h0:    rec_buf.addr[7:0] <= rx_sh;
									3'h1:    {rec_buf.be, rec_buf.addr[11:8]} <= rx_sh;
									default: rec_buf.data <= {rx_sh, rec_buf.data[31:8]};
								endcase
								if (byte_idx == SEL_REC_LAST_IDX) begin
									byte_idx <= 3'h0;
									state    <= SEL_ST_PUSH;
								end
							end
						end
						SEL_I_WRITE: begin
							{o_memory_select_n, gap_go} <= 2'h3;
							gap_instr                   <= SEL_I_RDSR;
							state                       <= SEL_ST_GAP;
						end
						SEL_I_RDSR: begin
							if (rx_sh[SEL_SR_BUSY_BIT]) begin
								{o_memory_select_n, gap_go} <= 2'h3;
								gap_instr                   <= SEL_I_RDSR;
								state                       <= SEL_ST_GAP;
							end else begin
								busy    <= 1'b0;
								cmd_ack <= !cmd_ack;
								{o_memory_select_n, gap_go} <= 2'h2;
								state                       <= SEL_ST_GAP;
							end
						end
						default: begin
							rd_q    <= rx_sh;
							cmd_ack <= !cmd_ack;
							{o_memory_select_n, gap_go} <= 2'h2;
							state                       <= SEL_ST_GAP;
						end
					endcase
				end
				SEL_ST_PUSH: if (rec_tog == lk_ack_s) begin
					rec_q     <= rec_buf;
					rec_tog   <= !rec_tog;
					remaining <= (remaining > SEL_REC_BYTES) ? remaining - SEL_REC_BYTES : 16'h0000;
					if (remaining <= SEL_REC_BYTES || pos == 16'h0000) begin
						done                        <= 1'b1;
						{o_memory_select_n, gap_go} <= 2'h2;
						state                       <= SEL_ST_GAP;
					end else begin
						state <= SEL_ST_DATA;
					end
				end
				SEL_ST_GAP: begin
					gap_cnt <= gap_cnt + 4'h1;
					if (gap_cnt == 4'(GAP_CYCLES - 1)) begin
						gap_cnt <= 4'h0;
						state   <= SEL_ST_IDLE;
						if (gap_go) begin
							instr             <= gap_instr;
							use16             <= (gap_instr == SEL_I_LOAD) ? try16 : mode16;
							o_memory_select_n <= 1'b0;
							state             <= SEL_ST_OP;
						end
					end
				end
				default: state <= SEL_ST_IDLE;
			endcase
		end
	end

	// Link status and toggles into the system domain
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sy_m <= SEL_STAT_RST;
			sy_s <= SEL_STAT_RST;
		end else begin
			sy_m <= {loading, busy, done, no_mem, mode16, rec_tog, cmd_ack};
			sy_s <= sy_m;
		end
	end

	assign rec_pend    = (sy_s.rec_tog != rec_seen);
	assign loading_all = sy_s.loading || rec_pend || o_csr_valid;

	// Record handed over once the buffer accepts it
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rec_seen <= 1'b0;
		end else if (rec_pend && buf_ready) begin
			rec_seen <= sy_s.rec_tog;
		end
	end

	sel_buffer #(
		.WIDTH ($bits(sel_rec_s)),
		.DEPTH (SEL_BUF_DEPTH)
	) u_buffer (
		.i_clock     (i_clock),
		.i_reset_n   (i_reset_n),
		.i_in_valid  (rec_pend),
		.o_in_ready  (buf_ready),
		.i_in_data   (rec_q),
		.o_out_valid (o_csr_valid),
		.i_out_ready (i_csr_ready),
		.o_out_data  (o_csr_rec)
	);

	// Host command take, busy ignore and read result
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			{cmd_hold, cmd_tog, ack_seen, was_read, o_cmd_taken, o_rd_valid, o_rd_data} <= '0;
		end else begin
			o_cmd_taken <= 1'b0;
			ack_seen    <= sy_s.cmd_ack;
			o_rd_valid  <= (sy_s.cmd_ack != ack_seen) && was_read;
			if (sy_s.cmd_ack != ack_seen) begin
				o_rd_data <= rd_q;
			end
			if (i_cmd_valid && !loading_all && !o_busy && (cmd_tog == sy_s.cmd_ack) && (sy_s.cmd_ack == ack_seen)) begin
				cmd_hold    <= i_cmd;
				cmd_tog     <= !cmd_tog;
				was_read    <= !i_cmd.write;
				o_cmd_taken <= 1'b1;
			end
		end
	end

	// Status flags and answers to requests during loading
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_loading <= 1'b1;
			{o_load_done, o_no_memory, o_addr16, o_busy, o_resp_valid, o_resp_retry, o_resp_ur} <= '0;
		end else begin
			o_loading    <= loading_all;
			o_load_done  <= !loading_all && sy_s.done;
			o_no_memory  <= sy_s.no_mem;
			o_addr16     <= sy_s.mode16;
			o_busy       <= sy_s.busy;
			o_resp_valid <= i_req_valid && loading_all;
			o_resp_retry <= i_req_valid && loading_all && i_req_cfg;
			o_resp_ur    <= i_req_valid && loading_all && !i_req_cfg;
		end
	end

	// Checks on the link side
	cs_hold_a: assert property (@(posedge i_link_clock) disable iff (!lk_rst_n)
		o_memory_serial_clock |-> !o_memory_select_n) else $error("clock high without select");
	mosi_stable_a: assert property (@(posedge i_link_clock) disable iff (!lk_rst_n)
		$changed(o_serial_data_to_memory) |-> !o_memory_serial_clock) else $error("data moved with clock high");
	rx_sample_a: assert property (@(posedge i_link_clock) disable iff (!lk_rst_n)
		$rose(o_memory_serial_clock) |-> rx_sh[0] == $past(lk_miso_s)) else $error("return bit not taken");
	op_a8_a: assert property (@(posedge i_link_clock) disable iff (!lk_rst_n)
		(state == SEL_ST_OP && !bit_run && !use16 && instr != SEL_I_WREN && instr != SEL_I_RDSR)
		|=> tx_sh[SEL_OP_A8_BIT] == $past(cur_addr[8]))
		else $error("A8 missing in opcode");
	op_plain_a: assert property (@(posedge i_link_clock) disable iff (!lk_rst_n)
		(state == SEL_ST_OP && !bit_run && (instr == SEL_I_WREN || instr == SEL_I_RDSR)) |=> !tx_sh[SEL_OP_A8_BIT])
		else $error("address bit in plain opcode");
	addr9_len_a: assert property (@(posedge i_link_clock) disable iff (!lk_rst_n)
		(state == SEL_ST_ADDR && byte_done && !use16) |=> state == SEL_ST_DATA) else $error("9-bit address too long");
	addr16_len_a: assert property (@(posedge i_link_clock) disable iff (!lk_rst_n)
		(state == SEL_ST_ADDR && byte_done && use16 && byte_idx == 3'h0) |=> state == SEL_ST_ADDR ##0 byte_idx == 3'h1)
		else $error("16-bit address too short");
	busy_start_a: assert property (@(posedge i_link_clock) disable iff (!lk_rst_n)
		$rose(busy) |-> state == SEL_ST_OP && instr == SEL_I_WREN) else $error("busy without write");
	nomem_end_a: assert property (@(posedge i_link_clock) disable iff (!lk_rst_n)
		$rose(no_mem) |-> try16 && !loading && done) else $error("absent memory before second try");
	round_end_a: assert property (@(posedge i_link_clock) disable iff (!lk_rst_n)
		(state == SEL_ST_PUSH && rec_tog == lk_ack_s && remaining <= SEL_REC_BYTES) |=> done ##0 state == SEL_ST_GAP)
		else $error("load ran past count");
	// Checks on the system side
	resp_retry_a: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		(i_req_valid && loading_all) |=> o_resp_valid && o_resp_retry == $past(i_req_cfg) && o_resp_ur != o_resp_retry)
		else $error("wrong answer while loading");
endmodule
`default_nettype wire

// File: hw/sel_pkg.sv
// Constants and carrier types for the serial configuration loader
package sel_pkg;
	// Image layout
	localparam logic [15:0] SEL_ID_CODE      = 16'h28AA;
	localparam logic [15:0] SEL_LOC_ID_HI    = 16'h0001;
	localparam logic [15:0] SEL_LOC_CNT_HI   = 16'h0003;
	localparam logic [15:0] SEL_LOC_REC0     = 16'h0004;
	localparam logic [15:0] SEL_REC_BYTES    = 16'h0006;
	localparam logic [2:0]  SEL_REC_LAST_IDX = 3'h5;
	localparam int          SEL_BE_LSB       = 4;
	// Memory instructions
	localparam logic [7:0]  SEL_OP_READ      = 8'h03;
	localparam logic [7:0]  SEL_OP_WRITE     = 8'h02;
	localparam logic [7:0]  SEL_OP_WREN      = 8'h06;
	localparam logic [7:0]  SEL_OP_RDSR      = 8'h05;
	localparam int          SEL_OP_A8_BIT    = 3;
	localparam int          SEL_SR_BUSY_BIT  = 0;
	// Link timing
	localparam int          SEL_LINK_PERIOD_NS = 48;
	localparam int          SEL_SCLK_HALF_NS   = 144;
	localparam int          SEL_HALF_CYC       = (SEL_SCLK_HALF_NS + SEL_LINK_PERIOD_NS - 1) / SEL_LINK_PERIOD_NS;
	localparam int          SEL_CS_GAP_NS      = 100;
	localparam int          SEL_CS_GAP_CYC     = (SEL_CS_GAP_NS + SEL_LINK_PERIOD_NS - 1) / SEL_LINK_PERIOD_NS;
	localparam int          SEL_BUF_DEPTH      = 2;

	// One register write taken from the image
	typedef struct packed {
		logic [3:0]  be;
		logic [11:0] addr;
		logic [31:0] data;
	} sel_rec_s;

	// Host command toward the memory
	typedef struct packed {
		logic        write;
		logic [15:0] addr;
		logic [7:0]  data;
	} sel_cmd_s;

	// Link status seen by the system clock
	typedef struct packed {
		logic loading;
		logic busy;
		logic done;
		logic no_mem;
		logic mode16;
		logic rec_tog;
		logic cmd_ack;
	} sel_stat_s;
	localparam sel_stat_s SEL_STAT_RST = 7'h40;

	typedef enum logic [2:0] {
		SEL_ST_IDLE = 3'h0,
		SEL_ST_GAP  = 3'h1,
		SEL_ST_OP   = 3'h3,
		SEL_ST_ADDR = 3'h2,
		SEL_ST_DATA = 3'h6,
		SEL_ST_PUSH = 3'h7
	} sel_state_e;

	typedef enum logic [2:0] {
		SEL_I_LOAD  = 3'h0,
		SEL_I_WREN  = 3'h1,
		SEL_I_WRITE = 3'h2,
		SEL_I_RDSR  = 3'h3,
		SEL_I_READ  = 3'h4
	} sel_instr_e;
endpackage

// File: hw/sel_buffer.sv
// Small valid/ready buffer with registered head entry
`timescale 1ns/1ns
`default_nettype none
module sel_buffer #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 2
) (
	input  wire logic             i_clock,
	input  wire logic             i_reset_n,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic [WIDTH-1:0]      o_out_data
);
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [CW-1:0]    count;
	logic [CW-1:0]    next_count;
	logic             push;
	logic             pop;

	// Handshakes and occupancy
	assign o_in_ready = (count != CW'(DEPTH));
	assign push       = i_in_valid && o_in_ready;
	assign pop        = o_out_valid && i_out_ready;
	assign next_count = count + CW'(push) - CW'(pop);
	assign o_out_data = mem[0];

	// Count and head valid
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			count       <= '0;
			o_out_valid <= 1'b0;
		end else begin
			count       <= next_count;
			o_out_valid <= (next_count != '0);
		end
	end

	// Entries shift toward the head on pop
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				if (pop) begin
					if (push && (int'(count) - 1 == i)) begin
						mem[i] <= i_in_data;
					end else if (i < DEPTH - 1) begin
						mem[i] <= mem[(i + 1) % DEPTH];
					end
				end else if (push && (int'(count) == i)) begin
					mem[i] <= i_in_data;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: verif/sel_mem_model.sv
// Behavioural serial configuration memory for the loader bench
`timescale 1ns/1ns
`default_nettype none
module sel_mem_model (
	input  wire logic       i_sclk,
	input  wire logic       i_mosi,
	input  wire logic       i_cs_n,
	input  wire logic [1:0] i_mode,
	output logic            o_miso
);
	logic [7:0]  mem [0:511];
	logic [7:0]  sh;
	logic [7:0]  op;
	logic [7:0]  ob;
	logic [15:0] addr;
	logic        drive;
	logic        wel;
	int          nb;
	int          kb;
	int          polls;
	// Idle line and no write pending at start
	initial begin
		o_miso = 1'b0;
		drive = 1'b0;
		wel = 1'b0;
		polls = 0;
	end
	// Select frames each instruction
	always @(negedge i_cs_n) begin
		nb = 0;
		kb = 0;
		drive = 1'b0;
	end
	always @(posedge i_cs_n) begin
		drive = 1'b0;
		o_miso = ~o_miso;
		if (op == 8'h02)
			wel = 1'b0;
	end
	// Opcode, address and write data taken on rising clock
	always @(posedge i_sclk) begin
		if (!i_cs_n && i_mode != 2'h2) begin
			sh = {sh[6:0], i_mosi};
			nb++;
			if (nb == 8) begin
				op = (i_mode == 2'h0 && (sh & 8'hF6) == 8'h02) ? (sh & 8'hF7) : sh;
				addr = (i_mode == 2'h0) ? {15'h0, sh[3]} : 16'h0;
				if (op == 8'h06)
					wel = 1'b1;
				if (op == 8'h05) begin
					ob = {7'h0, polls > 0};
					polls = (polls > 0) ? polls - 1 : 0;
					drive = 1'b1;
				end
			end else if (nb <= ((i_mode == 2'h0) ? 16 : 24)) begin
				addr = {addr[14:0], i_mosi};
				if (nb == ((i_mode == 2'h0) ? 16 : 24) && op == 8'h03) begin
					ob = mem[addr[8:0]];
					addr++;
					drive = 1'b1;
				end
			end else if (op == 8'h02 && wel && nb % 8 == 0) begin
				mem[addr[8:0]] = sh;
				addr++;
				polls = 2;
			end
		end
	end
	// Return data on falling clock, changing filler when not driving
	always @(negedge i_sclk) begin
		if (!i_cs_n && drive) begin
			o_miso = ob[7];
			ob = {ob[6:0], 1'b0};
			kb++;
			if (kb == 8) begin
				kb = 0;
				ob = (op == 8'h03) ? mem[addr[8:0]] : {7'h0, polls > 0};
				addr = (op == 8'h03) ? addr + 16'h1 : addr;
			end
		end else
			o_miso = ~o_miso;
	end
endmodule
`default_nettype wire

// File: verif/tb_sel_loader.sv
// Self-checking bench for the serial configuration loader
`timescale 1ns/1ns
`default_nettype none
module tb_sel_loader;
	import sel_pkg::*;
	logic       i_clock, i_link_clock, i_reset_n, sclk, mosi, miso, cs_n, hold_bit;
	logic       csr_valid, csr_ready, cmd_valid, cmd_taken, rd_valid, busy, loading, load_done;
	logic       no_memory, addr16, req_valid, req_cfg, resp_valid, resp_retry, resp_ur;
	logic [7:0] rd_data;
	logic [1:0] mem_mode;
	sel_rec_s   csr_rec;
	sel_rec_s   exp_rec [0:2];
	sel_cmd_s   cmd;
	int         miscompares, samples_checked, mosi_bad;

	sel_loader dut_u (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_link_clock(i_link_clock),
		.o_memory_serial_clock(sclk), .o_serial_data_to_memory(mosi), .i_serial_data_from_memory(miso),
		.o_memory_select_n(cs_n), .o_csr_valid(csr_valid), .i_csr_ready(csr_ready), .o_csr_rec(csr_rec),
		.i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_cmd_taken(cmd_taken), .o_rd_valid(rd_valid),
		.o_rd_data(rd_data), .o_busy(busy), .o_loading(loading), .o_load_done(load_done),
		.o_no_memory(no_memory), .o_addr16(addr16), .i_req_valid(req_valid), .i_req_cfg(req_cfg),
		.o_resp_valid(resp_valid), .o_resp_retry(resp_retry), .o_resp_ur(resp_ur));
	sel_mem_model mem_u (.i_sclk(sclk), .i_mosi(mosi), .i_cs_n(cs_n), .i_mode(mem_mode), .o_miso(miso));

	// System and unrelated link clocks
	initial begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end
	initial begin
		i_link_clock = 1'b0;
		#7;
		forever #24 i_link_clock = ~i_link_clock;
	end
	// Data toward memory must hold while serial clock is high
	always @(posedge sclk) hold_bit <= mosi;
	always @(posedge i_link_clock) if (!cs_n && sclk && mosi !== hold_bit) mosi_bad++;

	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Bounded wait at falling edges for an output to reach a level
	task automatic wait_for(input int sel, input logic lvl);
		int   n;
		logic v;
		n = 0;
		v = ~lvl;
		while (v !== lvl) begin
			@(negedge i_clock);
			case (sel)
				0: v = csr_valid;
				1: v = load_done;
				2: v = busy;
				3: v = rd_valid;
				default: v = cmd_taken;
			endcase
			n++;
			if (n > 30000) begin
				miscompares++;
				$display("BAD wait %0d expected %b seen timeout", sel, lvl);
				print_verdict();
			end
		end
	endtask

	// Image with identity, byte count and three records, then reset
	task automatic restart(input logic [1:0] mode, input logic [15:0] cnt);
		mem_mode = mode;
		for (int i = 0; i < 512; i++) mem_u.mem[i] = 8'h77;
		{mem_u.mem[1], mem_u.mem[0]} = SEL_ID_CODE;
		{mem_u.mem[3], mem_u.mem[2]} = cnt;
		for (int r = 0; r < 3; r++) begin
			mem_u.mem[4 + 6 * r] = exp_rec[r].addr[7:0];
			mem_u.mem[5 + 6 * r] = {exp_rec[r].be, exp_rec[r].addr[11:8]};
			{mem_u.mem[9 + 6 * r], mem_u.mem[8 + 6 * r], mem_u.mem[7 + 6 * r], mem_u.mem[6 + 6 * r]} = exp_rec[r].data;
		end
		i_reset_n = 1'b0;
		repeat (2) @(negedge i_clock);
		i_reset_n = 1'b1;
	endtask

	task automatic take_rec(input int r);
		wait_for(0, 1'b1);
		check("record", csr_rec, exp_rec[r]);
		csr_ready = 1'b1;
		@(negedge i_clock);
		csr_ready = 1'b0;
	endtask

	task automatic request(input logic cfg, input logic answer);
		req_valid = 1'b1;
		req_cfg = cfg;
		@(negedge i_clock);
		req_valid = 1'b0;
		check("response", 48'({resp_valid, resp_retry, resp_ur}), 48'(answer ? {1'b1, cfg, ~cfg} : 3'h0));
		@(negedge i_clock);
	endtask

	task automatic command(input logic wr, input logic [15:0] a, input logic [7:0] d);
		cmd = '{write: wr, addr: a, data: d};
		cmd_valid = 1'b1;
		wait_for(4, 1'b1);
		cmd_valid = 1'b0;
	endtask

	// Nine-bit memory, odd count rounded up, receiver stalls
	task automatic scn_nine();
		restart(2'h0, 16'd13);
		wait_for(0, 1'b1);
		repeat (1500) @(negedge i_clock);
		check("done early", 48'({load_done, loading}), 48'h1);
		request(1'b1, 1'b1);
		request(1'b0, 1'b1);
		for (int r = 0; r < 3; r++) take_rec(r);
		wait_for(1, 1'b1);
		check("status", 48'({csr_valid, no_memory, addr16, loading}), 48'h0);
		request(1'b1, 1'b0);
	endtask

	// Write above 0xFF, refused command while busy, read back
	task automatic scn_write();
		logic seen;
		seen = 1'b0;
		command(1'b1, 16'h01A5, 8'h5C);
		wait_for(2, 1'b1);
		cmd_valid = 1'b1;
		repeat (50) begin
			@(negedge i_clock);
			seen = seen | cmd_taken;
		end
		cmd_valid = 1'b0;
		check("taken busy", 48'(seen), 48'h0);
		wait_for(2, 1'b0);
		check("stored", 48'(mem_u.mem[9'h1A5]), 48'h5C);
		command(1'b0, 16'h01A5, 8'h00);
		wait_for(3, 1'b1);
		check("read", 48'(rd_data), 48'h5C);
	endtask

	// Sixteen-bit memory found on second try
	task automatic scn_sixteen();
		restart(2'h1, 16'd6);
		take_rec(0);
		wait_for(1, 1'b1);
		check("mode16", 48'({addr16, no_memory, csr_valid}), 48'h4);
		mem_u.mem[9'h1A5] = 8'hC3;
		command(1'b0, 16'h01A5, 8'h00);
		wait_for(3, 1'b1);
		check("read16", 48'(rd_data), 48'hC3);
	endtask

	// Nothing answers: absent memory, no records
	task automatic scn_absent();
		restart(2'h2, 16'd6);
		wait_for(1, 1'b1);
		check("absent", 48'({no_memory, csr_valid, loading}), 48'h4);
		request(1'b0, 1'b0);
	endtask

	// Main sequence
	initial begin
		csr_ready = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		req_valid = 1'b0;
		req_cfg = 1'b0;
		miscompares = 0;
		samples_checked = 0;
		mosi_bad = 0;
		exp_rec[0] = '{be: 4'h1, addr: 12'h005, data: 32'h11223344};
		exp_rec[1] = '{be: 4'hF, addr: 12'hABC, data: 32'hDEADBEEF};
		exp_rec[2] = '{be: 4'hA, addr: 12'hFFF, data: 32'h0055AA00};
		scn_nine();
		scn_write();
		scn_sixteen();
		scn_absent();
		check("data hold", 48'(mosi_bad), 48'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
